/* File: shared/asra_pkg.sv */
/*
  Shared constants for the accelerometer two-wire register access link.
  Assumes one 100 MHz clock per end and an open-drain bus resolved in the interface.
*/
package asra_pkg;
  localparam logic [6:0]  DEVICE_BUS_ADDRESS = 7'h1d;     // Fixed bus address 0011101
  localparam int          CLK_HZ             = 100_000_000;
  localparam int          BUS_HZ             = 1_000_000; // Bus clock made by the master
  localparam int          HALF_DIV           = CLK_HZ / (2 * BUS_HZ); // Cycles per bus half period
  localparam int          SAMPLE_DIV         = 1024;      // Cycles per new sample set (decimation 8 case)
  localparam logic [7:0]  REG_OFFSET_X       = 8'h16;     // First trimmed register
  localparam logic [7:0]  REG_CTRL2          = 8'h21;     // interface_control_two
  localparam logic [7:0]  REG_WAKE_CFG       = 8'h23;
  localparam logic [7:0]  REG_STATUS         = 8'h27;
  localparam logic [7:0]  REG_OUT_FIRST      = 8'h28;
  localparam logic [7:0]  REG_THS_L          = 8'h2e;
  localparam logic [7:0]  REG_THS_H          = 8'h2f;
  localparam int          THREE_WIRE_BIT     = 0;         // three_wire_select position in control two
  localparam int          WAKE_EN_BIT        = 0;         // Wake-up enable position in wake config
  localparam int          DF_LSB             = 4;         // decimation_factor field in control one
  localparam logic [7:0]  TRIM_RESET         = 8'h80;     // Value of the nonvolatile trim image
  localparam int          AXI_CTRL           = 0;         // Master command register
  localparam int          AXI_DATA           = 4;         // Master write byte / read byte
  localparam int          AXI_STATUS         = 8;         // Master status register
  localparam logic [31:0] AXI_ZERO           = 32'h0000_0000;
endpackage : asra_pkg

/* File: shared/asra_bus_if.sv */
/*
  Two-wire bus carrier with one modport per party.
  Assumes pull-ups: a line is low when any party enables its low drive.
*/
interface asra_bus_if;
  logic scl_o_m;   // Master clock drive value
  logic scl_oe_m;  // Master clock drive enable
  logic sda_o_m;   // Master data drive value
  logic sda_oe_m;  // Master data drive enable
  logic scl_o_s;   // Device clock stretch value
  logic scl_oe_s;  // Device clock stretch enable
  logic sda_o_s;   // Device data value
  logic sda_oe_s;  // Device data enable
  logic sel;       // Interface select strap, high for two-wire
  logic scl;       // Resolved clock line
  logic sda;       // Resolved data line
  // Wired-AND of both parties with pull-up
  assign scl = !((scl_oe_m && !scl_o_m) || (scl_oe_s && !scl_o_s));
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
  modport device (input scl, input sda, input sel, output scl_o_s, output scl_oe_s, output sda_o_s, output sda_oe_s);
  modport master (input scl, input sda, output sel, output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m);
endinterface : asra_bus_if

/* File: verilog/asra_sync.sv */
/*
  Two-flop synchroniser for the two bus lines.
  Assumes lines idle high; the first stage feeds only the second.
*/
module asra_sync (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_async,
  output logic      [1:0] o_sync
);
  typedef struct packed {
    logic [1:0] meta;  // First stage
    logic [1:0] sync;  // Second stage
  } asra_sync_state_type;
  asra_sync_state_type state;
  asra_sync_state_type next_state;
  // Shift both stages
  always_comb
  begin
    next_state      = state;
    next_state.meta = i_async;
    next_state.sync = state.meta;
  end
  // Idle-high reset value
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= '{meta: 2'b11, sync: 2'b11};
    else
      state <= next_state;
  end
  assign o_sync = state.sync;
endmodule : asra_sync

/* File: verilog/asra_device.sv */
/*
  Accelerometer end: two-wire slave over a 128-entry register array, sample source,
  data-ready and wake-up indications.
  Assumes the master generates the clock; bus lines pass the two-flop synchroniser.
*/
module asra_device (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  asra_bus_if.device      bus,
  output logic            o_sample_ready_signal,  // New sample set flag
  output logic            o_wake_irq,             // Threshold wake-up
  output logic            o_three_wire_select     // Serial port mode
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,  // Waiting for start
    ST_ADDR = 7'b000_0010,  // Shifting address byte
    ST_SUB  = 7'b000_0100,  // Shifting sub-address
    ST_WR   = 7'b000_1000,  // Shifting written data
    ST_ACK  = 7'b001_0000,  // Driving acknowledge
    ST_RD   = 7'b010_0000,  // Sending read data
    ST_MACK = 7'b100_0000   // Sampling master acknowledge
  } asra_dev_fsm_type;

  typedef struct packed {
    asra_dev_fsm_type fsm;        // Protocol state
    asra_dev_fsm_type after_ack;  // State after acknowledge
    logic [1:0]       prev;       // Previous synced {scl, sda}
    logic [7:0]       shift;      // Byte shifter
    logic [3:0]       bits;       // Bits moved in byte
    logic [6:0]       index;      // Register index
    logic             autoinc;    // Sub-address top bit
    logic             sda_low;    // Data line drive low
    logic             stretch;    // Clock held low
    logic             booted;     // Trim load done
    logic [6:0]       boot_idx;   // Trim load pointer
    logic [15:0]      div;        // Sample divider
    logic [7:0]       sample;     // Synthetic sample value
    logic             ready;      // Data-ready flag
    logic             wake;       // Wake-up flag
  } asra_dev_state_type;

  asra_dev_state_type state;
  asra_dev_state_type next_state;
  logic [7:0]         regs [128];  // Register array
  logic [7:0]         reg_rd;      // Read port
  logic [1:0]         line;        // Synced {scl, sda}
  logic               we;          // Register write strobe
  logic [6:0]         wa;          // Register write index
  logic [7:0]         wd;          // Register write data

  // Bus lines pass two flip-flops before use
  asra_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   ({bus.scl, bus.sda}),
    .o_sync    (line)
  );

  // Next index, wrapping in seven bits
  function automatic logic [6:0] step(input logic [6:0] idx, input logic inc);
    step = inc ? 7'(idx + 7'd1) : idx;
  endfunction : step

  assign reg_rd = regs[state.index];

  // Protocol, boot and sample logic
  always_comb
  begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [15:0] rate;
    rise       = line[1] && !state.prev[1];
    fall       = !line[1] && state.prev[1];
    start      = line[1] && state.prev[1] && state.prev[0] && !line[0];
    stop       = line[1] && state.prev[1] && !state.prev[0] && line[0];
    rate       = 16'(asra_pkg::SAMPLE_DIV);
    next_state = state;
    next_state.prev = line;
    we = 1'b0;
    wa = state.index;
    wd = state.shift;
    // Trim image copied before the bus is served
    if (!state.booted)
    begin
      // Whole array walked so control bits never start unknown; trim slots get the image
      we = 1'b1;
      wa = state.boot_idx;
      wd = 8'h00;
      if (state.boot_idx >= 7'(asra_pkg::REG_OFFSET_X) && state.boot_idx < 7'(asra_pkg::REG_OFFSET_X + 8'd6))
        wd = asra_pkg::TRIM_RESET;
      next_state.boot_idx = 7'(state.boot_idx + 7'd1);
      if (state.boot_idx == 7'h7f)
        next_state.booted = 1'b1;
    end
    // Sample divider: period scaled by decimation field
    next_state.div = 16'(state.div + 16'd1);
    rate = 16'(asra_pkg::SAMPLE_DIV) << regs[7'h20][asra_pkg::DF_LSB +: 2];
    if (state.div >= rate - 16'd1)
    begin
      next_state.div    = 16'h0000;
      next_state.sample = 8'(state.sample + 8'd3);
      next_state.ready  = 1'b1;
      if (regs[asra_pkg::REG_WAKE_CFG[6:0]][asra_pkg::WAKE_EN_BIT]
          && {state.sample, 8'h00} > {regs[asra_pkg::REG_THS_H[6:0]], regs[asra_pkg::REG_THS_L[6:0]]})
        next_state.wake = 1'b1;
    end
    // Bus protocol, only in two-wire select
    if (!bus.sel || !state.booted)
    begin
      next_state.fsm     = ST_IDLE;
      next_state.sda_low = 1'b0;
    end
    else if (stop)
    begin
      next_state.fsm     = ST_IDLE;
      next_state.sda_low = 1'b0;
    end
    else if (start)
    begin
      next_state.fsm     = ST_ADDR;
      next_state.bits    = 4'h0;
      next_state.sda_low = 1'b0;
    end
    else
    begin
      unique case (state.fsm)
        ST_IDLE: ;
        ST_ADDR, ST_SUB, ST_WR:
        begin
          if (rise)
          begin
            next_state.shift = {state.shift[6:0], line[0]};
            next_state.bits  = 4'(state.bits + 4'd1);
          end
          if (fall && state.bits == 4'd8)
          begin
            next_state.bits = 4'h0;
            if (state.fsm == ST_ADDR)
            begin
              if (state.shift[7:1] != asra_pkg::DEVICE_BUS_ADDRESS)
                next_state.fsm = ST_IDLE;
              else
              begin
                next_state.fsm       = ST_ACK;
                next_state.sda_low   = 1'b1;
                next_state.after_ack = state.shift[0] ? ST_RD : ST_SUB;
              end
            end
            else if (state.fsm == ST_SUB)
            begin
              next_state.index     = state.shift[6:0];
              next_state.autoinc   = state.shift[7];
              next_state.fsm       = ST_ACK;
              next_state.sda_low   = 1'b1;
              next_state.after_ack = ST_WR;
            end
            else
            begin
              we                   = 1'b1;
              next_state.index     = step(state.index, state.autoinc);
              next_state.fsm       = ST_ACK;
              next_state.sda_low   = 1'b1;
              next_state.after_ack = ST_WR;
            end
          end
        end
        ST_ACK:
        begin
          // Low held over the whole high phase unless entered from ST_MACK; after fall released, or set from bit 7 of the read byte
          if (fall)
          begin
            next_state.fsm = state.after_ack;
            next_state.sda_low = 1'b0;
            if (state.after_ack == ST_RD)
            begin
              next_state.shift   = reg_rd;
              next_state.sda_low = !reg_rd[7];
              next_state.bits    = 4'h1;
            end
          end
        end
        ST_RD:
        begin
          if (fall && state.bits == 4'd8)
          begin
            next_state.fsm     = ST_MACK;
            next_state.sda_low = 1'b0;
            next_state.index   = step(state.index, state.autoinc);
          end
          else if (fall)
          begin
            next_state.shift   = {state.shift[6:0], 1'b0};
            next_state.sda_low = !state.shift[6];
            next_state.bits    = 4'(state.bits + 4'd1);
          end
        end
        ST_MACK:
        begin
          if (rise)
            next_state.fsm = line[0] ? ST_IDLE : ST_ACK;
          next_state.after_ack = ST_RD;
        end
        default: next_state.fsm = ST_IDLE;
      endcase
    end
    // Reading the status register clears data-ready; a new set in the same cycle wins
    if (state.fsm == ST_ACK && fall && state.after_ack == ST_RD
        && state.index == asra_pkg::REG_STATUS[6:0] && state.div < rate - 16'd1)
      next_state.ready = 1'b0;
    // Register array never waits, so no stretch is needed
    next_state.stretch = 1'b0;
  end

  // Register array write port
  always_ff @(posedge i_ref_clk)
  begin
    if (we)
      regs[wa] <= wd;
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= '{fsm: ST_IDLE, after_ack: ST_SUB, prev: 2'b11, default: '0};
    else
      state <= next_state;
  end

  // Serial port mode follows control two bit
  logic three_wire;
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      three_wire <= 1'b0;
    else
      three_wire <= state.booted && regs[asra_pkg::REG_CTRL2[6:0]][asra_pkg::THREE_WIRE_BIT];
  end

  assign bus.sda_o_s          = 1'b0;
  assign bus.sda_oe_s         = state.sda_low;
  assign bus.scl_o_s          = 1'b0;
  assign bus.scl_oe_s         = state.stretch;
  assign o_sample_ready_signal = state.ready;
  assign o_wake_irq           = state.wake;
  assign o_three_wire_select  = three_wire;
endmodule : asra_device

/* File: verilog/asra_master.sv */
/*
  Microcontroller end: AXI4-Lite slave with command, data and status words, driving
  a two-wire bus master that moves one byte, with optional start and stop, or a bare stop per command.
  Assumes the device end on the same interface; lines pass the synchroniser.
*/
module asra_master (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  asra_bus_if.master       bus,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp
);
  typedef enum logic [4:0] {
    MS_IDLE  = 5'b00001,  // Waiting for a command
    MS_START = 5'b00010,  // Start or repeated start
    MS_BIT   = 5'b00100,  // Moving bits incl. acknowledge
    MS_STOP  = 5'b01000,  // Stop condition
    MS_DONE  = 5'b10000   // Command finished
  } asra_mst_fsm_type;

  typedef struct packed {
    asra_mst_fsm_type fsm;
    logic [15:0]      div;      // Half period divider
    logic [2:0]       phase;    // Step within condition or bit
    logic [3:0]       bits;     // Bit counter, 9 per byte
    logic [8:0]       shift;    // Byte plus acknowledge slot
    logic [8:0]       rx;       // Bits sampled from data line
    logic [2:0]       cmd;      // {stop, start, read}
    logic             ack_out;  // Acknowledge to send on read
    logic             scl;      // Clock drive high
    logic             sda;      // Data drive high
    logic             busy;
    logic             aw_got;
    logic             w_got;
    logic [31:0]      aw_addr;
    logic [31:0]      w_data;
    logic             bvalid;
    logic             rvalid;
    logic [31:0]      rdata;
  } asra_mst_state_type;

  asra_mst_state_type state;
  asra_mst_state_type next_state;
  logic [1:0]         line;  // Synced {scl, sda}

  asra_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   ({bus.scl, bus.sda}),
    .o_sync    (line)
  );

  // Bus clock enable, paused while the device stretches
  always_comb
  begin
    logic tick;
    tick       = 1'b0;
    next_state = state;
    next_state.div = 16'(state.div + 16'd1);
    if (state.div >= 16'(asra_pkg::HALF_DIV - 1))
    begin
      next_state.div = 16'h0000;
      tick = !(state.scl && !line[1]);
    end
    // AXI write channels taken in either order
    if (i_awvalid && !state.aw_got)
    begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = i_awaddr;
    end
    if (i_wvalid && !state.w_got)
    begin
      next_state.w_got  = 1'b1;
      next_state.w_data = i_wdata;
    end
    if (state.aw_got && state.w_got && !state.bvalid)
    begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      if (state.aw_addr[7:0] == 8'(asra_pkg::AXI_CTRL) && !state.busy && i_wstrb[0])
      begin
        next_state.cmd     = state.w_data[2:0];
        next_state.ack_out = state.w_data[3];
        // Reads send released bits and the chosen acknowledge, whatever DATA holds
        next_state.shift   = state.w_data[0] ? {8'hff, !state.w_data[3]} : state.shift;
        next_state.busy    = 1'b1;
        next_state.fsm     = state.w_data[1] ? MS_START : (state.w_data[2] && state.w_data[4] ? MS_STOP : MS_BIT);
        next_state.phase   = 3'h0;
        next_state.bits    = 4'h0;
      end
      else if (state.aw_addr[7:0] == 8'(asra_pkg::AXI_DATA))
        next_state.shift = {state.w_data[7:0], 1'b1};
    end
    if (state.bvalid && i_bready)
      next_state.bvalid = 1'b0;
    // AXI read answered one cycle after acceptance
    if (i_arvalid && !state.rvalid)
    begin
      next_state.rvalid = 1'b1;
      unique case (i_araddr[7:0])
        8'(asra_pkg::AXI_DATA):   next_state.rdata = {24'h00_0000, state.rx[8:1]};
        8'(asra_pkg::AXI_STATUS): next_state.rdata = {30'h0000_0000, state.rx[0], state.busy};
        default:                  next_state.rdata = asra_pkg::AXI_ZERO;
      endcase
    end
    if (state.rvalid && i_rready)
      next_state.rvalid = 1'b0;
    // Bus sequencing on half period ticks
    if (tick)
    begin
      unique case (state.fsm)
        MS_IDLE, MS_DONE: ;
        MS_START:
        begin
          // Release data, raise clock, pull data low, then clock low
          next_state.phase = 3'(state.phase + 3'd1);
          unique case (state.phase)
            3'd0: next_state.sda = 1'b1;
            3'd1: next_state.scl = 1'b1;
            3'd2: next_state.sda = 1'b0;
            default:
            begin
              next_state.scl   = 1'b0;
              next_state.phase = 3'h0;
              next_state.fsm   = MS_BIT;
            end
          endcase
          if (state.cmd[0])
            next_state.shift = {8'hff, !state.ack_out};
        end
        MS_BIT:
        begin
          if (!state.scl)
          begin
            // Data moves on the first low tick only, so it never changes as the clock rises
            if (!state.phase[0])
            begin
              next_state.sda   = state.shift[8];
              next_state.shift = {state.shift[7:0], 1'b1};
            end
            next_state.scl   = state.phase[0];
            next_state.phase = 3'(state.phase ^ 3'd1);
          end
          else
          begin
            next_state.scl   = 1'b0;
            next_state.rx    = {state.rx[7:0], line[0]};
            next_state.bits  = 4'(state.bits + 4'd1);
            next_state.phase = 3'h0;
            if (state.bits == 4'd8)
              next_state.fsm = state.cmd[2] ? MS_STOP : MS_DONE;
          end
        end
        MS_STOP:
        begin
          next_state.phase = 3'(state.phase + 3'd1);
          unique case (state.phase)
            3'd0: next_state.sda = 1'b0;
            3'd1: next_state.scl = 1'b1;
            default:
            begin
              next_state.sda = 1'b1;
              next_state.fsm = MS_DONE;
            end
          endcase
        end
        default: next_state.fsm = MS_IDLE;
      endcase
    end
    if (state.fsm == MS_DONE)
    begin
      next_state.busy = 1'b0;
      next_state.fsm  = MS_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= '{fsm: MS_IDLE, scl: 1'b1, sda: 1'b1, shift: 9'h1ff, default: '0};
    else
      state <= next_state;
  end

  assign bus.sel      = 1'b1;
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = !state.scl;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = !state.sda;
  assign o_awready    = !state.aw_got;
  assign o_wready     = !state.w_got;
  assign o_bvalid     = state.bvalid;
  assign o_bresp      = 2'b00;
  assign o_arready    = !state.rvalid;
  assign o_rvalid     = state.rvalid;
  assign o_rdata      = state.rdata;
  assign o_rresp      = 2'b00;
endmodule : asra_master

/* File: verification/asra_checker.sv */
/*
  Checks on the resolved two-wire lines between master end and device end.
  Assumes both ends share i_ref_clk and the lines are resolved by asra_bus_if.
*/
module asra_checker (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sel,
  input  wire logic scl_oe_s,
  input  wire logic sda_oe_s
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic       scl_q, sda_q;      // Lines one cycle back
  logic [3:0] bits;              // Clock rises in this byte
  logic [7:0] sh;                // Byte shifted in MSB first
  logic       first, wr, rd, mis; // Transfer phase flags
  logic       start_ev, stop_ev, rise, ack_rise, match;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign rise     = scl && !scl_q;
  assign ack_rise = rise && (bits == 4'h8);
  assign match    = (sh[7:1] == asra_pkg::DEVICE_BUS_ADDRESS);
  // Byte framer; a restart rise is counted, then the start that follows clears the count
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      {scl_q, sda_q} <= 2'h3;
      {bits, sh, first, wr, rd, mis} <= '0;
    end
    else
    begin
      {scl_q, sda_q} <= {scl, sda};
      if (start_ev || stop_ev)
      begin
        {bits, wr, rd, mis} <= '0;
        first <= start_ev;
      end
      else if (ack_rise)
      begin
        bits  <= 4'h0;
        first <= 1'b0;
        if (first)
        begin
          {wr, rd, mis} <= {match && !sh[0], match && sh[0], !match};
        end
      end
      else if (rise)
      begin
        bits <= bits + 4'h1;
        sh   <= {sh[6:0], sda};
      end
    end
  end
  property p_sel; sel; endproperty
  a_sel: assert property (p_sel) else $error("select strap low");
  property p_nostr; !scl_oe_s; endproperty
  a_nostr: assert property (p_nostr) else $error("device stretched clock");
  property p_hold; scl && scl_q |-> $stable(sda_oe_s); endproperty
  a_hold: assert property (p_hold) else $error("device data moved in clock high");
  property p_addr; ack_rise && first |-> sda_oe_s == match; endproperty
  a_addr: assert property (p_addr) else $error("address ack wrong");
  property p_wack; ack_rise && !first && wr |-> sda_oe_s; endproperty
  a_wack: assert property (p_wack) else $error("written byte not acked");
  property p_rrel; ack_rise && rd |-> !sda_oe_s; endproperty
  a_rrel: assert property (p_rrel) else $error("device held ack slot on read");
  property p_mis; mis |-> !sda_oe_s; endproperty
  a_mis: assert property (p_mis) else $error("unaddressed device drove data");
  property p_stop; stop_ev |=> !sda_oe_s [*8]; endproperty
  a_stop: assert property (p_stop) else $error("device drove data after stop");
endmodule : asra_checker

/* File: verification/tb_top.sv */
/*
  Bench for both ends: AXI4-Lite orders to the master end, checks at the device end.
  Assumes the master's CTRL/DATA/STATUS words and one 100 MHz clock for both ends.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [7:0] c; logic [7:0] d; logic [7:0] e; } asra_row_type; // Order, byte, rx
  localparam logic [7:0] AW = {asra_pkg::DEVICE_BUS_ADDRESS, 1'b0}; // Address with write direction
  localparam logic [7:0] AR = AW | 8'h01;                           // Address with read direction
  localparam logic [7:0] SB = 8'h80 | asra_pkg::REG_THS_L;          // Threshold pair, auto-increment
  localparam logic [7:0] SC = 8'h80 | asra_pkg::REG_CTRL2;          // Control two onward, auto-increment
  logic        i_ref_clk, i_reset, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rd, rdata;
  logic        awready, wready, bvalid, arready, rvalid, sready, wake, three;
  logic [1:0]  bresp, rresp;
  int          error_cnt, samples_checked;
  // Burst write of two bytes, burst read back over a repeated start; mode and wake burst
  // ending in a bare stop; one trim register read back
  asra_row_type rows [19] = '{'{8'h02, AW, 8'h00}, '{8'h00, SB, 8'h00}, '{8'h00, 8'h5c, 8'h00},
    '{8'h04, 8'h03, 8'h00}, '{8'h02, AW, 8'h00}, '{8'h00, SB, 8'h00}, '{8'h02, AR, 8'h00},
    '{8'h09, 8'h00, 8'h5c}, '{8'h05, 8'h00, 8'h03}, '{8'h02, AW, 8'h00}, '{8'h00, SC, 8'h00},
    '{8'h00, 8'h01, 8'h00}, '{8'h00, 8'h00, 8'h00}, '{8'h00, 8'h01, 8'h00}, '{8'h14, 8'h00, 8'h00},
    '{8'h02, AW, 8'h00}, '{8'h00, asra_pkg::REG_OFFSET_X, 8'h00}, '{8'h02, AR, 8'h00},
    '{8'h05, 8'h00, asra_pkg::TRIM_RESET}};
  asra_bus_if bus ();
  asra_device asra_device_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .bus(bus), .o_sample_ready_signal(sready),
    .o_wake_irq(wake), .o_three_wire_select(three));
  asra_master asra_master_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .bus(bus), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp));
  asra_checker asra_checker_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .scl(bus.scl), .sda(bus.sda),
    .sel(bus.sel), .scl_oe_s(bus.scl_oe_s), .sda_oe_s(bus.sda_oe_s));
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  // AXI write; each valid held until its own ready, bready until bvalid
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    do
    begin
      @(posedge i_ref_clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid);
  endtask : axw
  // AXI read; data taken at the rvalid edge
  task automatic axr(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    {arvalid, rready, araddr} <= {2'h3, a};
    do
    begin
      @(posedge i_ref_clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        d = rdata;
      end
    end while (!rvalid);
  endtask : axr
  // One byte order, then poll busy; last status stays in rd
  task automatic cmd(input logic [7:0] c, input logic [7:0] d);
    axw(asra_pkg::AXI_DATA, 32'(d));
    axw(asra_pkg::AXI_CTRL, 32'(c));
    do axr(asra_pkg::AXI_STATUS, rd); while (rd[0] === 1'b1);
  endtask : cmd
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Watchdog well above twenty bus bytes
  initial
  begin
    #600_000;
    error_cnt++;
    results();
  end
  initial
  begin
    {i_reset, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr, rd} = {1'b1, 5'h0, 128'h0};
    {error_cnt, samples_checked} = '0;
    repeat (5) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    repeat (130) @(posedge i_ref_clk); // Whole-array load at boot
    chk(32'({wake, three}), 32'h0000_0000);
    foreach (rows[k])
    begin
      cmd(rows[k].c, rows[k].d);
      if (rows[k].c[0])
      begin
        axr(asra_pkg::AXI_DATA, rd);
        chk(32'(rd[7:0]), 32'(rows[k].e));
      end
      else chk(32'(rd[1]), 32'h0000_0000);
    end
    chk(32'(sready), 32'h0000_0001);
    chk(32'(wake), 32'h0000_0001);
    chk(32'(three), 32'h0000_0001);
    // Foreign address is left unacknowledged
    cmd(8'h06, 8'h38);
    chk(32'(rd[1]), 32'h0000_0001);
    // Mid-run reset clears the flags and the mode bit while the array reloads
    i_reset <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk(32'({sready, wake, three}), 32'h0000_0000);
    results();
  end
endmodule : tb_top
